// >>> logic/ftu_top.sv
// Five-timer unit: two 16-bit and three 8-bit down counters behind APB.
// Function
// - Two 16-bit and three 8-bit down counters.
// - Underflow after zero reloads from latch.
// - Every underflow sets its request bit.
// - X and Y timer mode counts clock/16.
// - X pulse mode toggles pin on underflow.
// - X event mode counts its pin edges.
// - X pulse-width counts clock/16 while pin active.
// - X write control selects latch-only writes.
// - Latch-only write at underflow loads counter too.
// - X pin request follows edge select bit.
// - Real-time port updates on X underflow.
// - Y period mode reloads on pin edge.
// - Y keeps pre-reload value until read.
// - Y event mode counts its pin edges.
// - Y pin request edge; both edges in HL.
// - 8-bit sources selectable; timer 1 feeds 2/3.
// - Timer 2 write control selects latch-only writes.
// - Timer 2 output toggles on underflow.
`timescale 1ns/10ps
`default_nettype none
`include "ftu_regs.svh"
module ftu_top (
   input wire logic CLK_SYS,
   input wire logic SRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic TIMER_X_COUNT_PIN_IN,
   output logic TIMER_X_COUNT_PIN_OUT,
   output logic TIMER_X_COUNT_PIN_OE,
   input wire logic TIMER_Y_COUNT_PIN,
   input wire logic SUB_OSC_IN,
   output logic TIMER2_TOGGLE_OUT,
   output logic [1:0] RTP_OUT,
   output logic [6:0] IRQ_REQ
);
   // ==========================================================================
   // Software-visible state.
   logic [7:0] xmode; // Timer X mode register.
   logic [7:0] ymode; // Timer Y mode register.
   logic [7:0] tmode; // Timer 1-2-3 mode register.
   logic [7:0] wbuf_x; // Low byte held until the high byte is written.
   logic [7:0] wbuf_y; // Same for timer Y.
   logic [7:0] rbuf_x; // Low byte frozen when the high byte is read.
   logic [7:0] rbuf_y; // Same for timer Y.
   logic [15:0] ycap; // Timer Y value just before an edge reload.
   logic yhold; // Reads return ycap while set.
   logic rtp_en_d; // Previous real-time port enable.
   logic [3:0] pre; // Divide-by-16 prescaler.
   logic [3:0] pre2; // Further divide-by-16 for the slow 8-bit source.

   // ==========================================================================
   // APB decode. Every register answers with no wait state.
   wire setup = PSEL && !PENABLE;
   wire done = PSEL && PENABLE && PREADY;
   wire wr_done = done && PWRITE;
   wire rd_done = done && !PWRITE;
   wire [7:0] wd = PWDATA[7:0];
   wire hit_txl = PADDR == `FTU_A_TXL;
   wire hit_txh = PADDR == `FTU_A_TXH;
   wire hit_tyl = PADDR == `FTU_A_TYL;
   wire hit_tyh = PADDR == `FTU_A_TYH;
   wire hit_t1 = PADDR == `FTU_A_T1;
   wire hit_t2 = PADDR == `FTU_A_T2;
   wire hit_t3 = PADDR == `FTU_A_T3;
   wire hit_xm = PADDR == `FTU_A_XMODE;
   wire hit_ym = PADDR == `FTU_A_YMODE;
   wire hit_tm = PADDR == `FTU_A_TMODE;
   wire hit_irq = PADDR == `FTU_A_IRQ;
   wire mapped = hit_txl || hit_txh || hit_tyl || hit_tyh || hit_t1 || hit_t2 ||
      hit_t3 || hit_xm || hit_ym || hit_tm || hit_irq;

   // ==========================================================================
   // Pin synchronisers; nothing reads a raw pin.
   logic xp_lvl;
   logic xp_rise;
   logic xp_fall;
   logic yp_rise;
   logic yp_fall;
   logic sub_rise;
   ftu_pin_sync u_xsync (
      .clk(CLK_SYS),
      .rst(SRST),
      .pin(TIMER_X_COUNT_PIN_IN),
      .lvl(xp_lvl),
      .rise(xp_rise),
      .fall(xp_fall)
   );
   ftu_pin_sync u_ysync (
      .clk(CLK_SYS),
      .rst(SRST),
      .pin(TIMER_Y_COUNT_PIN),
      .lvl(),
      .rise(yp_rise),
      .fall(yp_fall)
   );
   ftu_pin_sync u_ssync (
      .clk(CLK_SYS),
      .rst(SRST),
      .pin(SUB_OSC_IN),
      .lvl(),
      .rise(sub_rise),
      .fall()
   );

   // ==========================================================================
   // Prescaler. The system clock stands for the main oscillator; with the
   // sub clock selected the prescaler steps on sub-oscillator rising edges.
   wire pre_step = tmode[`FTU_TM_SUB] ? sub_rise : 1'b1;
   wire div16 = pre_step && (pre == `FTU_DIV_LAST);
   wire div256 = div16 && (pre2 == `FTU_DIV_LAST);

   // Prescaler counters free-run from reset.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         pre <= '0;
         pre2 <= '0;
      end else begin
         if (pre_step) begin
            pre <= pre + 4'h1;
         end
         if (div16) begin
            pre2 <= pre2 + 4'h1;
         end
      end
   end

   // ==========================================================================
   // Mode decode.
   wire ftu_pkg::ftu_xmode_t xm = ftu_pkg::ftu_xmode_t'(xmode[1:0]);
   wire ftu_pkg::ftu_ymode_t ym = ftu_pkg::ftu_ymode_t'(ymode[1:0]);
   wire x_edge = xmode[`FTU_XM_EDGE] ? xp_fall : xp_rise;
   wire y_sel_edge = ymode[`FTU_YM_EDGE] ? yp_fall : yp_rise;
   wire y_hl = ym == ftu_pkg::FTU_Y_HL;
   wire y_trig = y_hl ? (yp_rise || yp_fall) : y_sel_edge;
   wire y_meas = (ym == ftu_pkg::FTU_Y_PERIOD) || y_hl;
   wire y_reload = y_meas && y_trig;
   // Pulse-width gate: count while pin high (edge bit 0) or low (bit 1).
   wire x_gate = xp_lvl != xmode[`FTU_XM_EDGE];
   wire x_tick = (xm == ftu_pkg::FTU_X_EVENT) ? x_edge :
      (xm == ftu_pkg::FTU_X_PWIDTH) ? (div16 && x_gate) : div16;
   wire y_tick = (ym == ftu_pkg::FTU_Y_EVENT) ? y_sel_edge : div16;

   // ==========================================================================
   // Counters.
   ftu_cnt_if #(.W(16)) x_if ();
   ftu_cnt_if #(.W(16)) y_if ();
   ftu_cnt_if #(.W(8)) t1_if ();
   ftu_cnt_if #(.W(8)) t2_if ();
   ftu_cnt_if #(.W(8)) t3_if ();

   // A 16-bit write commits on the high byte, after the low byte.
   wire commit_x = wr_done && hit_txh;
   wire commit_y = wr_done && hit_tyh;
   assign x_if.tick = x_tick;
   assign x_if.val = {wd, wbuf_x};
   assign x_if.wr_lat = commit_x;
   assign x_if.wr_cnt = commit_x && !xmode[`FTU_XM_WC];
   assign x_if.reload = 1'b0;
   assign y_if.tick = y_tick;
   assign y_if.val = {wd, wbuf_y};
   assign y_if.wr_lat = commit_y;
   assign y_if.wr_cnt = commit_y;
   assign y_if.reload = y_reload;

   // 8-bit sources: timer 1 from /16 or /256; timers 2, 3 from timer 1 or /16.
   assign t1_if.tick = tmode[`FTU_TM_T1SRC] ? div256 : div16;
   assign t2_if.tick = tmode[`FTU_TM_T2SRC] ? div16 : t1_if.unf;
   assign t3_if.tick = tmode[`FTU_TM_T3SRC] ? div16 : t1_if.unf;
   assign t1_if.val = wd;
   assign t2_if.val = wd;
   assign t3_if.val = wd;
   assign t1_if.wr_lat = wr_done && hit_t1;
   assign t1_if.wr_cnt = wr_done && hit_t1;
   assign t2_if.wr_lat = wr_done && hit_t2;
   assign t2_if.wr_cnt = wr_done && hit_t2 && !tmode[`FTU_TM_T2WC];
   assign t3_if.wr_lat = wr_done && hit_t3;
   assign t3_if.wr_cnt = wr_done && hit_t3;
   assign t1_if.reload = 1'b0;
   assign t2_if.reload = 1'b0;
   assign t3_if.reload = 1'b0;

   // Five counters share one module; reload on underflow lives inside.
   ftu_down_cnt #(.W(16), .RST(`FTU_RST_16)) u_tx (
      .clk(CLK_SYS),
      .rst(SRST),
      .bus(x_if.owner)
   );
   ftu_down_cnt #(.W(16), .RST(`FTU_RST_16)) u_ty (
      .clk(CLK_SYS),
      .rst(SRST),
      .bus(y_if.owner)
   );
   ftu_down_cnt #(.W(8), .RST(`FTU_RST_8)) u_t1 (
      .clk(CLK_SYS),
      .rst(SRST),
      .bus(t1_if.owner)
   );
   ftu_down_cnt #(.W(8), .RST(`FTU_RST_8)) u_t2 (
      .clk(CLK_SYS),
      .rst(SRST),
      .bus(t2_if.owner)
   );
   ftu_down_cnt #(.W(8), .RST(`FTU_RST_8)) u_t3 (
      .clk(CLK_SYS),
      .rst(SRST),
      .bus(t3_if.owner)
   );

   // ==========================================================================
   // Request bits. A set in the same cycle as its clear wins.
   logic [6:0] irq_set;
   always_comb begin
      irq_set = '0;
      irq_set[`FTU_IRQ_TX] = x_if.unf;
      irq_set[`FTU_IRQ_TY] = y_if.unf;
      irq_set[`FTU_IRQ_T1] = t1_if.unf;
      irq_set[`FTU_IRQ_T2] = t2_if.unf;
      irq_set[`FTU_IRQ_T3] = t3_if.unf;
      irq_set[`FTU_IRQ_CX] = x_edge;
      irq_set[`FTU_IRQ_CY] = y_trig;
   end
   wire [6:0] irq_clr = (wr_done && hit_irq) ? wd[6:0] : 7'h00;

   // ==========================================================================
   // Read path. Timer Y returns the captured value while it is held.
   wire [15:0] y_view = yhold ? ycap : y_if.cnt;
   wire [7:0] rd_mux =
      hit_txl ? rbuf_x :
      hit_txh ? x_if.cnt[15:8] :
      hit_tyl ? rbuf_y :
      hit_tyh ? y_view[15:8] :
      hit_t1 ? t1_if.cnt :
      hit_t2 ? t2_if.cnt :
      hit_t3 ? t3_if.cnt :
      hit_xm ? xmode :
      hit_ym ? ymode :
      hit_tm ? tmode :
      hit_irq ? {1'b0, IRQ_REQ} : 8'h00;

   // APB answer: ready and data are registered at the setup edge.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         PREADY <= 1'b0;
         PRDATA <= '0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= setup;
         // The error flag stands only beside ready, never past the access cycle.
         PSLVERR <= setup && !mapped;
         if (setup) begin
            PRDATA <= {24'h000000, rd_mux};
         end
      end
   end

   // Mode registers and byte buffers.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         xmode <= '0;
         ymode <= '0;
         tmode <= '0;
         wbuf_x <= '0;
         wbuf_y <= '0;
      end else if (wr_done) begin
         if (hit_xm) xmode <= wd;
         if (hit_ym) ymode <= wd;
         if (hit_tm) tmode <= wd;
         if (hit_txl) wbuf_x <= wd;
         if (hit_tyl) wbuf_y <= wd;
      end
   end

   // Reading the high byte freezes the low byte so the pair is coherent.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         rbuf_x <= '0;
         rbuf_y <= '0;
      end else if (rd_done) begin
         if (hit_txh) rbuf_x <= x_if.cnt[7:0];
         if (hit_tyh) rbuf_y <= y_view[7:0];
      end
   end

   // Capture before an edge reload; a new capture beats the read release.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         ycap <= '0;
         yhold <= 1'b0;
      end else if (y_reload) begin
         ycap <= y_if.cnt;
         yhold <= 1'b1;
      end else if (rd_done && hit_tyl) begin
         yhold <= 1'b0;
      end
   end

   // Request register, also driven straight onto the request outputs.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         IRQ_REQ <= '0;
      end else begin
         IRQ_REQ <= (IRQ_REQ & ~irq_clr) | irq_set;
      end
   end

   // ==========================================================================
   // Pin outputs. Pulse mode drives the X count pin; other modes release it.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         TIMER_X_COUNT_PIN_OUT <= 1'b0;
         TIMER_X_COUNT_PIN_OE <= 1'b0;
         TIMER2_TOGGLE_OUT <= 1'b0;
      end else begin
         TIMER_X_COUNT_PIN_OE <= xm == ftu_pkg::FTU_X_PULSE;
         if (xm == ftu_pkg::FTU_X_PULSE && x_if.unf) begin
            TIMER_X_COUNT_PIN_OUT <= !TIMER_X_COUNT_PIN_OUT;
         end
         if (tmode[`FTU_TM_T2OE] && t2_if.unf) begin
            TIMER2_TOGGLE_OUT <= !TIMER2_TOGGLE_OUT;
         end
      end
   end

   // Real-time port: loads at once when enabled, then on each X underflow.
   // Data rewritten while enabled waits for the next underflow.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         rtp_en_d <= 1'b0;
         RTP_OUT <= '0;
      end else begin
         rtp_en_d <= xmode[`FTU_XM_RTP_EN];
         if (xmode[`FTU_XM_RTP_EN] && (!rtp_en_d || x_if.unf)) begin
            RTP_OUT <= xmode[`FTU_XM_RTP_HI:`FTU_XM_RTP_LO];
         end
      end
   end
endmodule
`default_nettype wire

// >>> logic/ftu_regs.svh
// Register offsets, field positions and reset values of the five-timer unit.
`ifndef FTU_REGS_SVH
`define FTU_REGS_SVH
// ==========================================================================
// APB byte offsets
`define FTU_A_TXL 8'h00
`define FTU_A_TXH 8'h04
`define FTU_A_TYL 8'h08
`define FTU_A_TYH 8'h0c
`define FTU_A_T1 8'h10
`define FTU_A_T2 8'h14
`define FTU_A_T3 8'h18
`define FTU_A_XMODE 8'h1c
`define FTU_A_YMODE 8'h20
`define FTU_A_TMODE 8'h24
`define FTU_A_IRQ 8'h28
// ==========================================================================
// Timer X mode fields
`define FTU_XM_EDGE 2
`define FTU_XM_WC 3
`define FTU_XM_RTP_EN 4
`define FTU_XM_RTP_LO 5
`define FTU_XM_RTP_HI 6
// Timer Y mode field
`define FTU_YM_EDGE 2
// Timer 1-2-3 mode fields
`define FTU_TM_T1SRC 0
`define FTU_TM_T2SRC 1
`define FTU_TM_T3SRC 2
`define FTU_TM_T2OE 3
`define FTU_TM_T2WC 4
`define FTU_TM_SUB 5
// ==========================================================================
// Request bit positions
`define FTU_IRQ_TX 0
`define FTU_IRQ_TY 1
`define FTU_IRQ_T1 2
`define FTU_IRQ_T2 3
`define FTU_IRQ_T3 4
`define FTU_IRQ_CX 5
`define FTU_IRQ_CY 6
// ==========================================================================
// Reset values and prescaler
`define FTU_RST_16 16'hffff
`define FTU_RST_8 8'hff
`define FTU_DIV_LAST 4'hf
`endif

// >>> logic/ftu_pkg.sv
// Mode types of the five-timer unit.
package ftu_pkg;
   // Timer X operating modes, in register encoding order.
   typedef enum logic [1:0] {FTU_X_TIMER, FTU_X_PULSE, FTU_X_EVENT, FTU_X_PWIDTH} ftu_xmode_t;
   // Timer Y operating modes, in register encoding order.
   typedef enum logic [1:0] {FTU_Y_TIMER, FTU_Y_PERIOD, FTU_Y_EVENT, FTU_Y_HL} ftu_ymode_t;
endpackage

// >>> logic/ftu_cnt_if.sv
// Interface between the top and one reloadable down counter.
`timescale 1ns/10ps
`default_nettype none
interface ftu_cnt_if #(parameter int W = 8);
   logic tick; // Count pulse.
   logic wr_cnt; // Load counter from val.
   logic wr_lat; // Load latch from val.
   logic reload; // Edge-triggered reload from latch.
   logic [W-1:0] val; // Written value.
   logic [W-1:0] cnt; // Counter value.
   logic unf; // Underflow pulse.
   modport user (output tick, wr_cnt, wr_lat, reload, val, input cnt, unf);
   modport owner (input tick, wr_cnt, wr_lat, reload, val, output cnt, unf);
endinterface
`default_nettype wire

// >>> logic/ftu_pin_sync.sv
// Two-stage pin synchroniser with edge detection.
`timescale 1ns/10ps
`default_nettype none
module ftu_pin_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   output logic lvl,
   output logic rise,
   output logic fall
);
   logic s1; // First stage, read only by s2.
   logic s2; // Synchronised level.
   logic s3; // Previous synchronised level.
   // ==========================================================================
   // Synchroniser chain.
   always_ff @(posedge clk) begin
      if (rst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end
   assign lvl = s2;
   assign rise = s2 && !s3;
   assign fall = !s2 && s3;
endmodule
`default_nettype wire

// >>> logic/ftu_down_cnt.sv
// Down counter with reload latch, shared by all five timers.
`timescale 1ns/10ps
`default_nettype none
module ftu_down_cnt #(
   parameter int W = 8,
   parameter logic [W-1:0] RST = {W{1'b1}}
) (
   input wire logic clk,
   input wire logic rst,
   ftu_cnt_if.owner bus
);
   logic [W-1:0] latch; // Reload latch.
   logic [W-1:0] cnt_q; // Counter.
   wire [W-1:0] dec = cnt_q - 1'b1;
   // Underflow happens on the count pulse after zero.
   assign bus.cnt = cnt_q;
   assign bus.unf = bus.tick && (cnt_q == '0);
   // ==========================================================================
   // A latch write that meets an underflow lands in the counter too.
   always_ff @(posedge clk) begin
      if (rst) begin
         latch <= RST;
         cnt_q <= RST;
      end else begin
         if (bus.wr_lat) begin
            latch <= bus.val;
         end
         if (bus.wr_cnt || (bus.wr_lat && bus.unf)) begin
            cnt_q <= bus.val;
         end else if (bus.reload || bus.unf) begin
            cnt_q <= latch;
         end else if (bus.tick) begin
            cnt_q <= dec;
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/ftu_top_props.sv
// Port-level assertions of the five-timer unit.
`timescale 1ns/10ps
`default_nettype none
module ftu_top_props (
   input wire logic CLK_SYS,
   input wire logic SRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic TIMER_X_COUNT_PIN_OUT,
   input wire logic TIMER_X_COUNT_PIN_OE,
   input wire logic TIMER2_TOGGLE_OUT,
   input wire logic [6:0] IRQ_REQ
);
   // A setup cycle of a transfer.
   wire setup = PSEL && !PENABLE;
   // A completed write to the request register.
   wire irq_wr = PSEL && PENABLE && PREADY && PWRITE && (PADDR == 8'h28);
   // Request bits that fell at this edge.
   logic [6:0] dropped;
   // One domain, so clock and reset are given once.
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SRST);
   a_ready_setup: assert property (setup |=> PREADY) else $error("no ready after setup");
   a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held too long");
   a_err_unmapped: assert property (setup && PADDR > 8'h28 |=> PSLVERR && PRDATA == 32'h0)
      else $error("unmapped access not refused");
   a_ok_mapped: assert property (setup && PADDR <= 8'h28 && PADDR[1:0] == 2'b00 |=> !PSLVERR)
      else $error("mapped access refused");
   a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
   a_rdata_byte: assert property (PREADY |-> PRDATA[31:8] == 24'h0) else $error("upper data set");
   // The past values of a one-edge reset are excluded, since reset clears requests.
   a_irq_sticky: assert property (!$past(SRST) && ($past(IRQ_REQ) & ~IRQ_REQ) != 7'h0 |->
      $past(irq_wr) && ($past(IRQ_REQ) & ~IRQ_REQ & ~$past(PWDATA[6:0])) == 7'h0)
      else $error("request bit lost without clear");
   a_xout_unf: assert property ($changed(TIMER_X_COUNT_PIN_OUT) |->
      TIMER_X_COUNT_PIN_OE ##[0:1] IRQ_REQ[0]) else $error("x pin toggled without underflow");
   a_t2out_unf: assert property ($changed(TIMER2_TOGGLE_OUT) |-> ##[0:1] IRQ_REQ[3])
      else $error("timer 2 output toggled without underflow");
endmodule
`default_nettype wire

// >>> tb/ftu_pin_drv.sv
// Model of the external pins feeding the five-timer unit.
`timescale 1ns/10ps
`default_nettype none
module ftu_pin_drv (
   input wire logic clk,
   output logic x_pin,
   output logic y_pin,
   output logic sub_osc
);
   // Pins idle low; the sub oscillator stands still as it is never selected.
   initial begin
      x_pin = 1'b0;
      y_pin = 1'b0;
      sub_osc = 1'b0;
   end
   // Drive one pin right after a rising edge.
   task automatic drive(input logic sel, input logic lvl);
      @(posedge clk);
      if (sel) begin
         y_pin <= lvl;
      end else begin
         x_pin <= lvl;
      end
   endtask
   // Pulses are four cycles each way, wide enough for the synchroniser.
   task automatic pulse(input logic sel, input int n);
      repeat (n) begin
         drive(sel, 1'b1);
         repeat (3) @(posedge clk);
         drive(sel, 1'b0);
         repeat (3) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench of the five-timer unit.
`timescale 1ns/10ps
`default_nettype none
`include "ftu_regs.svh"
module tb_top;
   logic clk_sys = 1'b0; // System clock.
   logic srst = 1'b1; // Synchronous reset.
   logic psel = 1'b0; // APB select.
   logic penable = 1'b0; // APB enable.
   logic pwrite = 1'b0; // APB direction.
   logic [7:0] paddr = 8'h00; // APB address.
   logic [31:0] pwdata = 32'h0; // APB write data.
   logic [31:0] prdata;
   logic pready, pslverr, x_out, x_oe, x_pin, y_pin, sub_osc, t2_out;
   logic [1:0] rtp;
   logic [6:0] irq;
   int error_cnt = 0; // Mismatches seen.
   int checks_done = 0; // Comparisons made.
   int seed = 32'ha340; // Fixed seed keeps runs repeatable.
   logic [31:0] rd; // Last read data.
   logic err; // Last error response.
   logic [15:0] v; // Last 16-bit read.
   logic [15:0] w; // Random 16-bit value.
   logic [7:0] n; // Random small value.
   int k; // Random pulse count.
   ftu_top i_ftu_top (.CLK_SYS(clk_sys), .SRST(srst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .TIMER_X_COUNT_PIN_IN(x_pin), .TIMER_X_COUNT_PIN_OUT(x_out),
      .TIMER_X_COUNT_PIN_OE(x_oe), .TIMER_Y_COUNT_PIN(y_pin), .SUB_OSC_IN(sub_osc),
      .TIMER2_TOGGLE_OUT(t2_out), .RTP_OUT(rtp), .IRQ_REQ(irq));
   ftu_pin_drv i_ftu_pin_drv (.clk(clk_sys), .x_pin(x_pin), .y_pin(y_pin), .sub_osc(sub_osc));
   // ==========================================================================
   // Clock of 40 ns period.
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   // Count comparisons and report a mismatch at once.
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         error_cnt++;
      end
   endtask
   // A condition counts as met only when it is a clean one.
   task automatic ok(input string what, input logic cond);
      chk(what, 16'h1, {15'h0, cond});
   endtask
   // Event count left after k edges; wraps at 16 bits, with no reload from the latch.
   function automatic logic [15:0] exp_evt(input logic [15:0] s, input int e);
      return s - 16'(e);
   endfunction
   // One APB transfer; the request is held until ready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      // Only the watchdog ends a wait for ready.
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   // Sixteen-bit accesses: low written first, high read first.
   task automatic wr16(input logic [7:0] lo, input logic [15:0] d);
      apb(1'b1, lo, d[7:0]);
      apb(1'b1, lo + 8'h04, d[15:8]);
   endtask
   task automatic rd16(input logic [7:0] lo);
      apb(1'b0, lo + 8'h04, 8'h00);
      v[15:8] = rd[7:0];
      apb(1'b0, lo, 8'h00);
      v[7:0] = rd[7:0];
   endtask
   // Wait, bounded, for one request bit.
   task automatic wait_irq(input int b, input int lim);
      int t;
      t = 0;
      while (irq[b] !== 1'b1 && t < lim) begin
         @(posedge clk_sys);
         t++;
      end
      ok("irq wait", irq[b]);
   endtask
   // Reset for five cycles, then check what reset leaves; counters may have begun counting.
   task automatic reset_chk;
      srst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      rd16(`FTU_A_TXL);
      ok("x reset", v >= 16'hfffd);
      rd16(`FTU_A_TYL);
      ok("y reset", v >= 16'hfffd);
      for (int i = 4; i < 11; i++) begin
         apb(1'b0, 8'(i * 4), 8'h00);
         if (i < 7) ok("t reset", rd[7:0] >= 8'hf8);
         else chk("mode reset", 16'h0, rd[15:0]);
      end
      chk("out reset", 16'h0, {12'h0, rtp, t2_out, x_oe});
      $display("test reset done");
   endtask
   // Print counts and the verdict, then end the run.
   task automatic close_out;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ==========================================================================
   // Main sequence.
   initial begin
      reset_chk();
      apb(1'b1, 8'h2c, 8'($random(seed)));
      ok("wr refused", err);
      apb(1'b0, 8'h30, 8'h00);
      ok("rd refused", err);
      chk("rd zero", 16'h0, rd[15:0]);
      $display("test unmapped done");
      n = 8'($unsigned($random(seed)) % 6 + 2);
      apb(1'b1, `FTU_A_T1, n);
      wait_irq(2, 400);
      apb(1'b0, `FTU_A_T1, 8'h00);
      ok("t1 reload", rd[7:0] <= n && rd[7:0] >= n - 8'h01);
      apb(1'b1, `FTU_A_IRQ, 8'h04);
      apb(1'b0, `FTU_A_IRQ, 8'h00);
      chk("t1 clear", 16'h0, {15'h0, rd[2]});
      $display("test t1 done");
      apb(1'b1, `FTU_A_TMODE, 8'h0a);
      apb(1'b1, `FTU_A_IRQ, 8'h08);
      apb(1'b1, `FTU_A_T2, 8'h03);
      apb(1'b0, `FTU_A_T2, 8'h00);
      ok("t2 direct", rd[7:0] <= 8'h03);
      apb(1'b1, `FTU_A_TMODE, 8'h1a);
      apb(1'b1, `FTU_A_T2, 8'h40);
      apb(1'b0, `FTU_A_T2, 8'h00);
      ok("t2 latch only", rd[7:0] <= 8'h03);
      wait_irq(3, 200);
      chk("t2 toggle", 16'h1, {15'h0, t2_out});
      apb(1'b0, `FTU_A_T2, 8'h00);
      ok("t2 reload", rd[7:0] > 8'h03 && rd[7:0] <= 8'h40);
      $display("test t2 done");
      apb(1'b1, `FTU_A_XMODE, 8'h01);
      @(posedge clk_sys);
      ok("x oe", x_oe);
      apb(1'b1, `FTU_A_IRQ, 8'h01);
      wr16(`FTU_A_TXL, 16'h0040);
      apb(1'b1, `FTU_A_XMODE, 8'h09);
      wr16(`FTU_A_TXL, 16'h1234);
      rd16(`FTU_A_TXL);
      ok("x latch only", v <= 16'h0040);
      wait_irq(0, 1400);
      chk("x toggle", 16'h1, {15'h0, x_out});
      rd16(`FTU_A_TXL);
      ok("x reload", v <= 16'h1234 && v >= 16'h1230);
      $display("test x pulse done");
      w = 16'($random(seed)) | 16'h0100;
      k = $unsigned($random(seed)) % 4 + 1;
      apb(1'b1, `FTU_A_XMODE, 8'h02);
      apb(1'b1, `FTU_A_IRQ, 8'h20);
      wr16(`FTU_A_TXL, w);
      i_ftu_pin_drv.pulse(1'b0, k);
      rd16(`FTU_A_TXL);
      chk("x events", exp_evt(w, k), v);
      ok("x pin irq", irq[5]);
      apb(1'b1, `FTU_A_XMODE, 8'h03);
      wr16(`FTU_A_TXL, w);
      repeat (40) @(posedge clk_sys);
      rd16(`FTU_A_TXL);
      chk("x width gate", w, v);
      i_ftu_pin_drv.drive(1'b0, 1'b1);
      repeat (40) @(posedge clk_sys);
      i_ftu_pin_drv.drive(1'b0, 1'b0);
      rd16(`FTU_A_TXL);
      ok("x width count", v < w && v >= w - 16'h0004);
      n = 8'($random(seed));
      apb(1'b1, `FTU_A_XMODE, {1'b0, n[1:0], 5'h10});
      repeat (3) @(posedge clk_sys);
      chk("rtp", {14'h0, n[1:0]}, {14'h0, rtp});
      $display("test x event done");
      apb(1'b1, `FTU_A_YMODE, 8'h02);
      wr16(`FTU_A_TYL, w);
      i_ftu_pin_drv.pulse(1'b1, k);
      rd16(`FTU_A_TYL);
      chk("y events", exp_evt(w, k), v);
      apb(1'b1, `FTU_A_YMODE, 8'h01);
      apb(1'b1, `FTU_A_IRQ, 8'h40);
      i_ftu_pin_drv.pulse(1'b1, 1);
      ok("y period irq", irq[6]);
      rd16(`FTU_A_TYL);
      rd16(`FTU_A_TYL);
      ok("y reload", v <= w && v >= w - 16'h0003);
      apb(1'b1, `FTU_A_YMODE, 8'h07);
      apb(1'b1, `FTU_A_IRQ, 8'h40);
      i_ftu_pin_drv.drive(1'b1, 1'b1);
      repeat (5) @(posedge clk_sys);
      ok("y both edges", irq[6]);
      // Return the pin to its idle level so no edge follows the next reset.
      i_ftu_pin_drv.drive(1'b1, 1'b0);
      $display("test y done");
      reset_chk();
      close_out();
   end
   // Watchdog well beyond the few thousand cycles the tests need.
   initial begin
      repeat (40000) @(posedge clk_sys);
      error_cnt++;
      close_out();
   end
endmodule
bind ftu_top ftu_top_props i_ftu_top_props (.CLK_SYS(CLK_SYS), .SRST(SRST), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .TIMER_X_COUNT_PIN_OUT(TIMER_X_COUNT_PIN_OUT),
   .TIMER_X_COUNT_PIN_OE(TIMER_X_COUNT_PIN_OE), .TIMER2_TOGGLE_OUT(TIMER2_TOGGLE_OUT),
   .IRQ_REQ(IRQ_REQ));
`default_nettype wire
